// ### design/tog_pkg.sv
// Purpose: Constants for the timing output generator block
// Assumes: 125 MHz timebase clock, classic Wishbone register access
// Notes: Register offsets are byte addresses of 32-bit words
`default_nettype none
package tog_pkg;
  localparam int CLK_HZ = 125000000;
  localparam int NUM_OUT = 4;
  localparam int NUM_FREQ = 3;
  localparam int NUM_IRIG = 2;
  localparam int SEL_W = 4;
  // Source codes for the output selectors
  localparam logic [3:0] SRC_PPS = 4'h0;
  localparam logic [3:0] SRC_FREQ1 = 4'h1;
  localparam logic [3:0] SRC_FREQ2 = 4'h2;
  localparam logic [3:0] SRC_FREQ3 = 4'h3;
  localparam logic [3:0] SRC_IRIG1 = 4'h4;
  localparam logic [3:0] SRC_IRIG2 = 4'h5;
  localparam logic [3:0] SRC_GNSS = 4'h6;
  localparam logic [3:0] SRC_IN1 = 4'h7;
  localparam logic [3:0] SRC_IN2 = 4'h8;
  localparam logic [3:0] SRC_OSC = 4'h9;
  // Frequency limits in Hz
  localparam int FREQ_MIN_HZ = 2;
  localparam int FREQ_MAX_HZ = 10000000;
  // Time-code rates in pulses per second
  localparam int IRIG_B_PPS = 100;
  localparam int IRIG_G_PPS = 10000;
  localparam logic [31:0] IRIG_B_DIV = 32'(CLK_HZ / IRIG_B_PPS);
  localparam logic [31:0] IRIG_G_DIV = 32'(CLK_HZ / IRIG_G_PPS);
  localparam logic [31:0] SEC_CYCLES = 32'(CLK_HZ);
  // Half-period limits; the shortest half rounds up so no divider runs above the top frequency
  localparam logic [31:0] FREQ_LIMIT_MAX = 32'(CLK_HZ / (2 * FREQ_MIN_HZ));
  localparam logic [31:0] FREQ_LIMIT_MIN = 32'((CLK_HZ + 2 * FREQ_MAX_HZ - 1) / (2 * FREQ_MAX_HZ));
  // Register byte offsets
  localparam logic [7:0] REG_OUT_CTRL = 8'h00;
  localparam logic [7:0] REG_PPS_CTRL = 8'h04;
  localparam logic [7:0] REG_PPS_WIDTH = 8'h08;
  localparam logic [7:0] REG_PPS_DELAY = 8'h0C;
  localparam logic [7:0] REG_FREQ_CTRL = 8'h10;
  localparam logic [7:0] REG_FREQ_HALF0 = 8'h14;
  localparam logic [7:0] REG_FREQ_DELAY0 = 8'h20;
  localparam logic [7:0] REG_IRIG_CTRL = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  // Reset values
  localparam logic [31:0] PPS_WIDTH_RST = 32'h00BEBC20;
  localparam logic [31:0] FREQ_HALF_RST = 32'h0000003E;
  // Time-code coded-expression legal set
  localparam logic [7:0] IRIG_CODE_OK = 8'hCF;
  typedef enum logic {IRIG_RATE_B, IRIG_RATE_G} tog_rate_type;
endpackage : tog_pkg
`default_nettype wire

// ### design/tog_divider.sv
// Purpose: Numerical divider producing a square wave on the timebase
// Assumes: Half period and advance given in clock cycles
// Notes: Advance shifts the phase earlier relative to the epoch
`timescale 1ns/1ns
`default_nettype none
module tog_divider (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic epoch_i,
  input wire logic [31:0] half_i,
  input wire logic [31:0] adv_i,
  output logic wave_o
);
  logic [31:0] cnt_reg;
  logic wave_reg;
  logic [31:0] start_w;
  // Phase preload: the count starts ahead by the advance, or at zero when the advance is not below a half period
  assign start_w = (adv_i < half_i) ? adv_i : 32'h00000000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 32'h00000000;
      wave_reg <= 1'b0;
    end else if (!en_i) begin
      // Preload while idle so the advance holds from enable, not only from the next epoch
      cnt_reg <= start_w;
      wave_reg <= 1'b0;
    end else if (epoch_i) begin
      cnt_reg <= start_w;
      wave_reg <= 1'b1;
    end else if (cnt_reg >= half_i - 32'h00000001) begin
      cnt_reg <= 32'h00000000;
      wave_reg <= ~wave_reg;
    end else begin
      cnt_reg <= cnt_reg + 32'h00000001;
    end
  end
  assign wave_o = wave_reg;
endmodule // tog_divider
`default_nettype wire

// ### design/tog_irig.sv
// Purpose: Time-code symbol timing generator
// Assumes: Frame content is built elsewhere; this shapes the symbol rate
// Notes: Symbol width follows a simple marker/one/zero pattern by code
`timescale 1ns/1ns
`default_nettype none
module tog_irig (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic rate_g_i,
  input wire logic [2:0] code_i,
  output logic sig_o
);
  logic [31:0] cnt_reg;
  logic [6:0] sym_reg;
  logic sig_reg;
  logic [31:0] per_w;
  logic [31:0] hi_w;
  assign per_w = rate_g_i ? tog_pkg::IRIG_G_DIV : tog_pkg::IRIG_B_DIV;
  // Markers at symbol 0 and each symbol whose low four bits are 9 are about 81 percent high, others follow code bit
  always_comb begin
    if (sym_reg == 7'h00 || sym_reg[3:0] == 4'h9) begin
      hi_w = (per_w >> 2) + (per_w >> 1) + (per_w >> 4);
    end else if (code_i[(sym_reg[1:0] == 2'h3) ? 2'h2 : sym_reg[1:0]]) begin
      hi_w = per_w >> 1;
    end else begin
      hi_w = per_w >> 2;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_reg <= 32'h00000000;
      sym_reg <= 7'h00;
      sig_reg <= 1'b0;
    end else begin
      sig_reg <= cnt_reg < hi_w;
      if (cnt_reg >= per_w - 32'h00000001) begin
        cnt_reg <= 32'h00000000;
        sym_reg <= (sym_reg == 7'h63) ? 7'h00 : sym_reg + 7'h01;
      end else begin
        cnt_reg <= cnt_reg + 32'h00000001;
      end
    end
  end
  assign sig_o = sig_reg;
endmodule // tog_irig
`default_nettype wire

// ### design/tog_top.sv
// Purpose: Timing generators and output routing with Wishbone registers
// Assumes: CLK_I is the high-resolution timebase at 125 MHz
// Notes: Outputs change only on CLK_I edges
`timescale 1ns/1ns
`default_nettype none
module tog_top (
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [7:0] ADR_I,
  input wire logic [3:0] SEL_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic GNSS_PPS_I,
  input wire logic IN1_I,
  input wire logic IN2_I,
  input wire logic OSC_I,
  output logic [3:0] OUT_O,
  output logic OUT5_O,
  output logic OUT5_VALID_O
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] out_ctrl_reg;
  logic [31:0] pps_ctrl_reg;
  logic [31:0] pps_width_reg;
  logic [31:0] pps_delay_reg;
  logic [31:0] freq_ctrl_reg;
  logic [31:0] freq_half_reg [tog_pkg::NUM_FREQ];
  logic [31:0] freq_delay_reg [tog_pkg::NUM_FREQ];
  logic [31:0] irig_ctrl_reg;
  logic ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_next;
  logic wr_w;
  logic [31:0] wmask_w;
  assign wr_w = CYC_I && STB_I && WE_I && ack_reg;
  assign wmask_w = {{8{SEL_I[3]}}, {8{SEL_I[2]}}, {8{SEL_I[1]}}, {8{SEL_I[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction

  function automatic logic [31:0] clamp_half(input logic [31:0] v);
    if (v < tog_pkg::FREQ_LIMIT_MIN) begin
      clamp_half = tog_pkg::FREQ_LIMIT_MIN;
    end else if (v > tog_pkg::FREQ_LIMIT_MAX) begin
      clamp_half = tog_pkg::FREQ_LIMIT_MAX;
    end else begin
      clamp_half = v;
    end
  endfunction

  // Bus answers one cycle after the request, then drops ack; writes commit on the ack edge
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= CYC_I && STB_I && !ack_reg;
      dat_reg <= rd_next;
    end
  end
  assign ACK_O = ack_reg;
  assign DAT_O = dat_reg;

  // Out ctrl: per output [3:0] source, [4] invert, [5] enable, byte per output
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      out_ctrl_reg <= 32'h00000000;
    end else if (wr_w && ADR_I == tog_pkg::REG_OUT_CTRL) begin
      out_ctrl_reg <= merge(out_ctrl_reg, DAT_I, wmask_w) & 32'h3F3F3F3F;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pps_ctrl_reg <= 32'h00000000;
      pps_width_reg <= tog_pkg::PPS_WIDTH_RST;
      pps_delay_reg <= 32'h00000000;
    end else if (wr_w) begin
      if (ADR_I == tog_pkg::REG_PPS_CTRL) pps_ctrl_reg <= merge(pps_ctrl_reg, DAT_I, wmask_w) & 32'h00000003;
      if (ADR_I == tog_pkg::REG_PPS_WIDTH) pps_width_reg <= merge(pps_width_reg, DAT_I, wmask_w);
      if (ADR_I == tog_pkg::REG_PPS_DELAY) pps_delay_reg <= merge(pps_delay_reg, DAT_I, wmask_w);
    end
  end

  // Frequency ctrl: bit i enable, bit 4+i polarity; half period clamped to range
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      freq_ctrl_reg <= 32'h00000000;
    end else if (wr_w && ADR_I == tog_pkg::REG_FREQ_CTRL) begin
      freq_ctrl_reg <= merge(freq_ctrl_reg, DAT_I, wmask_w) & 32'h00000077;
    end
  end

  // Time-code ctrl: per generator byte [0] enable, [1] rate G, [4:2] code
  // An illegal code write leaves the old code in place
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      irig_ctrl_reg <= 32'h00000000;
    end else if (wr_w && ADR_I == tog_pkg::REG_IRIG_CTRL) begin
      for (int k = 0; k < tog_pkg::NUM_IRIG; k++) begin
        if (SEL_I[k]) begin
          irig_ctrl_reg[8*k +: 2] <= DAT_I[8*k +: 2];
          if (tog_pkg::IRIG_CODE_OK[DAT_I[8*k+2 +: 3]]) begin
            irig_ctrl_reg[8*k+2 +: 3] <= DAT_I[8*k+2 +: 3];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Generators
  // ----------------------------------------------------------------
  logic [31:0] sec_cnt_reg;
  logic epoch_w;
  logic pps_raw_reg;
  logic [31:0] pps_phase_w;
  logic [2:0] freq_wave;
  logic [1:0] irig_wave;
  assign epoch_w = sec_cnt_reg == tog_pkg::SEC_CYCLES - 32'h00000001;

  // Free-running second counter shared by the pulse and frequency generators
  always_ff @(posedge CLK_I) begin
    if (SRST_I || epoch_w) begin
      sec_cnt_reg <= 32'h00000000;
    end else begin
      sec_cnt_reg <= sec_cnt_reg + 32'h00000001;
    end
  end

  // Delay taken modulo one second so the pulse lands early by that amount
  assign pps_phase_w = (sec_cnt_reg + pps_delay_reg) % tog_pkg::SEC_CYCLES;

  always_ff @(posedge CLK_I) begin
    if (SRST_I || !pps_ctrl_reg[0]) begin
      pps_raw_reg <= 1'b0;
    end else begin
      pps_raw_reg <= pps_phase_w < pps_width_reg;
    end
  end

  generate
    for (genvar g = 0; g < tog_pkg::NUM_FREQ; g++) begin : g_freq
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          freq_half_reg[g] <= tog_pkg::FREQ_HALF_RST;
          freq_delay_reg[g] <= 32'h00000000;
        end else if (wr_w) begin
          if (ADR_I == tog_pkg::REG_FREQ_HALF0 + 8'(4 * g)) begin
            freq_half_reg[g] <= clamp_half(DAT_I);
          end
          if (ADR_I == tog_pkg::REG_FREQ_DELAY0 + 8'(4 * g)) begin
            freq_delay_reg[g] <= DAT_I;
          end
        end
      end
      // Divider phase aligned to the second; non-integer ratios keep a small error
      tog_divider u_div (
        .clk_i(CLK_I),
        .rst_i(SRST_I),
        .en_i(freq_ctrl_reg[g]),
        .epoch_i(epoch_w),
        .half_i(freq_half_reg[g]),
        .adv_i(freq_delay_reg[g]),
        .wave_o(freq_wave[g])
      );
    end
    for (genvar g = 0; g < tog_pkg::NUM_IRIG; g++) begin : g_irig
      tog_irig u_irig (
        .clk_i(CLK_I),
        .rst_i(SRST_I),
        .en_i(irig_ctrl_reg[8*g]),
        .rate_g_i(irig_ctrl_reg[8*g+1]),
        .code_i(irig_ctrl_reg[8*g+2 +: 3]),
        .sig_o(irig_wave[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pass-through synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pt_meta_reg;
  logic [3:0] pt_sync_reg;
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      pt_meta_reg <= 4'h0;
      pt_sync_reg <= 4'h0;
    end else begin
      pt_meta_reg <= {OSC_I, IN2_I, IN1_I, GNSS_PPS_I};
      pt_sync_reg <= pt_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Output routing
  // ----------------------------------------------------------------
  logic [15:0] src_w;
  logic [3:0] out_reg;
  logic out5_reg;
  logic out5_valid_reg;
  // Generator polarity applies before the output invert
  assign src_w = {6'h00, pt_sync_reg, irig_wave,
    freq_wave ^ freq_ctrl_reg[6:4], pps_raw_reg ^ pps_ctrl_reg[1]};

  generate
    for (genvar o = 0; o < tog_pkg::NUM_OUT; o++) begin : g_out
      always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
          out_reg[o] <= 1'b0;
        end else begin
          out_reg[o] <= out_ctrl_reg[8*o+5] && (src_w[out_ctrl_reg[8*o +: 4]] ^ out_ctrl_reg[8*o+4]);
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      out5_reg <= 1'b0;
      out5_valid_reg <= 1'b0;
    end else begin
      out5_valid_reg <= irig_ctrl_reg[8] && !irig_ctrl_reg[9];
      out5_reg <= irig_wave[1] && !irig_ctrl_reg[9];
    end
  end
  assign OUT_O = out_reg;
  assign OUT5_O = out5_reg;
  assign OUT5_VALID_O = out5_valid_reg;

  // Read mux
  always_comb begin
    rd_next = 32'h00000000;
    unique case (ADR_I)
      tog_pkg::REG_OUT_CTRL: rd_next = out_ctrl_reg;
      tog_pkg::REG_PPS_CTRL: rd_next = pps_ctrl_reg;
      tog_pkg::REG_PPS_WIDTH: rd_next = pps_width_reg;
      tog_pkg::REG_PPS_DELAY: rd_next = pps_delay_reg;
      tog_pkg::REG_FREQ_CTRL: rd_next = freq_ctrl_reg;
      tog_pkg::REG_FREQ_HALF0: rd_next = freq_half_reg[0];
      8'h18: rd_next = freq_half_reg[1];
      8'h1C: rd_next = freq_half_reg[2];
      tog_pkg::REG_FREQ_DELAY0: rd_next = freq_delay_reg[0];
      8'h24: rd_next = freq_delay_reg[1];
      8'h28: rd_next = freq_delay_reg[2];
      tog_pkg::REG_IRIG_CTRL: rd_next = irig_ctrl_reg;
      tog_pkg::REG_STATUS: rd_next = {20'h00000, out5_valid_reg, out5_reg, out_reg, irig_wave, freq_wave, pps_raw_reg};
      default: rd_next = 32'h00000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_out_disabled;
    @(posedge CLK_I) disable iff (SRST_I)
    !out_ctrl_reg[5] |=> !out_reg[0];
  endproperty
  a_out_disabled: assert property (p_out_disabled) else $error("output 1 active while disabled");

  property p_out_route;
    @(posedge CLK_I) disable iff (SRST_I)
    out_ctrl_reg[5] && $stable(out_ctrl_reg) |=> out_reg[0] == ($past(src_w[out_ctrl_reg[3:0]]) ^ $past(out_ctrl_reg[4]));
  endproperty
  a_out_route: assert property (p_out_route) else $error("output 1 not the selected source");

  property p_out5_g;
    @(posedge CLK_I) disable iff (SRST_I)
    irig_ctrl_reg[9] |=> !out5_reg && !out5_valid_reg;
  endproperty
  a_out5_g: assert property (p_out5_g) else $error("output 5 active in rate G");

  property p_out5_follow;
    @(posedge CLK_I) disable iff (SRST_I)
    !irig_ctrl_reg[9] |=> out5_reg == $past(irig_wave[1]);
  endproperty
  a_out5_follow: assert property (p_out5_follow) else $error("output 5 not following time-code 2");

  property p_code_legal;
    @(posedge CLK_I) disable iff (SRST_I)
    tog_pkg::IRIG_CODE_OK[irig_ctrl_reg[4:2]] && tog_pkg::IRIG_CODE_OK[irig_ctrl_reg[12:10]];
  endproperty
  a_code_legal: assert property (p_code_legal) else $error("illegal coded expression held");

  property p_pps_off;
    @(posedge CLK_I) disable iff (SRST_I)
    !pps_ctrl_reg[0] |=> !pps_raw_reg;
  endproperty
  a_pps_off: assert property (p_pps_off) else $error("pulse while generator disabled");

  property p_half_range;
    @(posedge CLK_I) disable iff (SRST_I)
    freq_half_reg[0] >= tog_pkg::FREQ_LIMIT_MIN && freq_half_reg[0] <= tog_pkg::FREQ_LIMIT_MAX;
  endproperty
  a_half_range: assert property (p_half_range) else $error("divider out of range");

  property p_ack_once;
    @(posedge CLK_I) disable iff (SRST_I)
    ack_reg |=> !ack_reg;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

  property p_ack_answer;
    @(posedge CLK_I) disable iff (SRST_I)
    CYC_I && STB_I && !ack_reg |=> ack_reg;
  endproperty
  a_ack_answer: assert property (p_ack_answer) else $error("request not answered next cycle");

  property p_freq_off;
    @(posedge CLK_I) disable iff (SRST_I)
    !freq_ctrl_reg[0] |=> !freq_wave[0];
  endproperty
  a_freq_off: assert property (p_freq_off) else $error("divider running while disabled");

  property p_epoch_pps;
    @(posedge CLK_I) disable iff (SRST_I)
    epoch_w && pps_ctrl_reg[0] && pps_delay_reg == 32'h00000000 && pps_width_reg != 32'h00000000 ##1 $stable(pps_ctrl_reg) |-> ##1 pps_raw_reg;
  endproperty
  a_epoch_pps: assert property (p_epoch_pps) else $error("pulse missing at second start");

  c_out5: cover property (@(posedge CLK_I) disable iff (SRST_I) out5_valid_reg && out5_reg);
  c_multi: cover property (@(posedge CLK_I) disable iff (SRST_I) out_ctrl_reg[5] && out_ctrl_reg[13] && out_ctrl_reg[3:0] == out_ctrl_reg[11:8]);
  c_pps: cover property (@(posedge CLK_I) disable iff (SRST_I) $rose(pps_raw_reg));
  c_irig_g: cover property (@(posedge CLK_I) disable iff (SRST_I) irig_ctrl_reg[1] && out_ctrl_reg[3:0] == tog_pkg::SRC_IRIG1 && out_reg[0]);
endmodule // tog_top
`default_nettype wire

// ### tb/tog_far_end.sv
// Purpose: Far-side equipment model for the timing outputs
// Assumes: Pass-through sources change only on clock edges
// Notes: Measures edge spacing on outputs 1 and 2
`timescale 1ns/1ns
`default_nettype none
module tog_far_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] lvl_i,
  input wire logic [3:0] out_i,
  output logic gnss_o,
  output logic in1_o,
  output logic in2_o,
  output logic osc_o,
  output logic [31:0] period_o,
  output logic [31:0] lag_o,
  output logic [31:0] rises_o
);
  // ----------------------------------------
  // Source pins and edge timers
  // ----------------------------------------
  logic [3:0] pins = 4'h0;
  logic [1:0] last_reg;
  logic [31:0] since0_reg;
  logic [31:0] since1_reg;
  assign {osc_o, in2_o, in1_o, gnss_o} = pins;
  always @(posedge clk_i) begin
    pins <= lvl_i;
  end
  // Period counts from one rising edge of output 1 to the next
  always @(posedge clk_i) begin
    if (rst_i) begin
      last_reg <= 2'b00;
      since0_reg <= 32'h0;
      since1_reg <= 32'h0;
      period_o <= 32'h0;
      lag_o <= 32'h0;
      rises_o <= 32'h0;
    end else begin
      last_reg <= out_i[1:0];
      since0_reg <= since0_reg + 32'h1;
      since1_reg <= since1_reg + 32'h1;
      if (out_i[1] && !last_reg[1]) begin
        since1_reg <= 32'h0;
      end
      if (out_i[0] && !last_reg[0]) begin
        period_o <= since0_reg + 32'h1;
        lag_o <= since1_reg + 32'h1;
        rises_o <= rises_o + 32'h1;
        since0_reg <= 32'h0;
      end
    end
  end
endmodule // tog_far_end
`default_nettype wire

// ### tb/tog_top_tb_top.sv
// Purpose: Self-checking bench for the timing output block
// Assumes: Classic Wishbone master, 125 MHz clock
// Notes: Random values come from a fixed-seed shift register
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
module tog_top_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [3:0] lvl = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] lfsr = 32'h0001863A;
  logic [31:0] dat_o, rd, r, h, ctl, period, lag, rises;
  logic [3:0] out, inv, ena;
  logic [3:0] src [4];
  logic [2:0] exp_code;
  logic ack, out5, out5_v, gnss, in1, in2, osc;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] adr_t [4] = '{8'hFC, 8'h00, 8'h08, 8'h14};
  logic [31:0] exp_t [4] = '{32'h0, 32'h0, tog_pkg::PPS_WIDTH_RST, tog_pkg::FREQ_HALF_RST};
  initial begin
    forever #4 clk = ~clk;
  end
  tog_top i_dut (.CLK_I(clk), .SRST_I(rst), .CYC_I(cyc), .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel),
    .DAT_I(wdat), .DAT_O(dat_o), .ACK_O(ack), .GNSS_PPS_I(gnss), .IN1_I(in1), .IN2_I(in2), .OSC_I(osc),
    .OUT_O(out), .OUT5_O(out5), .OUT5_VALID_O(out5_v));
  tog_far_end i_far (.clk_i(clk), .rst_i(rst), .lvl_i(lvl), .out_i(out), .gnss_o(gnss), .in1_o(in1),
    .in2_o(in2), .osc_o(osc), .period_o(period), .lag_o(lag), .rises_o(rises));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic logic code_ok(logic [2:0] c);
    return (c != 3'h4) && (c != 3'h5);
  endfunction
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  // A cycle limit bounds every wait, so a dead generator ends as a failure
  task automatic wait_rises(input int k, input int lim);
    logic [31:0] r0;
    int n;
    r0 = rises;
    n = 0;
    while (rises - r0 < k && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) fail_count++;
  endtask
  task automatic summarize();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("out_reset", 4'h0, out)
    wb(1'b1, 8'hFC, 32'hFFFFFFFF);
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, adr_t[i], 32'h0);
      `CHK("reset_reg", exp_t[i], rd)
    end
    // Source 3 copies source 2 so one pass-through input always feeds two outputs
    for (int it = 0; it < 6; it++) begin
      r = rnd();
      for (int k = 0; k < 4; k++) begin
        src[k] = 4'h6 + 4'(r[2*k +: 2]);
        inv[k] = r[8+k];
        ena[k] = (it != 0) || (k != 0);
      end
      src[3] = src[2];
      for (int k = 0; k < 4; k++) ctl[8*k +: 8] = {2'b00, ena[k], inv[k], src[k]};
      lvl <= r[15:12];
      wb(1'b1, tog_pkg::REG_OUT_CTRL, ctl);
      repeat (8) @(posedge clk);
      for (int k = 0; k < 4; k++) `CHK("out_pass", ena[k] & (lvl[src[k] - 4'h6] ^ inv[k]), out[k])
    end
    // Far from a second start: the wide default pulse is high, a one-cycle pulse is low
    wb(1'b1, tog_pkg::REG_PPS_CTRL, 32'h1);
    wb(1'b1, tog_pkg::REG_OUT_CTRL, 32'h00000020);
    repeat (4) @(posedge clk);
    `CHK("pps_on", 1'b1, out[0])
    wb(1'b1, tog_pkg::REG_PPS_WIDTH, 32'h1);
    repeat (4) @(posedge clk);
    `CHK("pps_width", 1'b0, out[0])
    wb(1'b1, tog_pkg::REG_PPS_CTRL, 32'h3);
    repeat (4) @(posedge clk);
    `CHK("pps_polarity", 1'b1, out[0])
    wb(1'b1, tog_pkg::REG_FREQ_HALF0, 32'h14);
    wb(1'b1, 8'h18, 32'h14);
    wb(1'b1, 8'h24, 32'h3);
    wb(1'b1, tog_pkg::REG_OUT_CTRL, 32'h00002221);
    wb(1'b1, tog_pkg::REG_FREQ_CTRL, 32'h3);
    wait_rises(3, 400);
    `CHK("advance", 32'h3, lag)
    `CHK("period", 32'h28, period)
    for (int it = 0; it < 4; it++) begin
      h = (it == 0) ? 32'h5 : 32'hC + (rnd() & 32'h1F);
      wb(1'b1, tog_pkg::REG_FREQ_HALF0, h);
      wait_rises(4, 600);
      // 10 MHz at 125 MHz needs a half of 6.25 cycles, so the shortest legal half is 7
      `CHK("period", 32'h2 * ((h < 32'h7) ? 32'h7 : h), period)
    end
    exp_code = 3'h0;
    for (int c = 0; c < 8; c++) begin
      wb(1'b1, tog_pkg::REG_IRIG_CTRL, {27'h0, 3'(c), 2'b01});
      if (code_ok(3'(c))) exp_code = 3'(c);
      wb(1'b0, tog_pkg::REG_IRIG_CTRL, 32'h0);
      `CHK("irig_code", {exp_code, 2'b01}, rd[4:0])
    end
    wb(1'b1, tog_pkg::REG_IRIG_CTRL, 32'h00000101);
    repeat (4) @(posedge clk);
    `CHK("out5_valid", 1'b1, out5_v)
    wb(1'b1, tog_pkg::REG_IRIG_CTRL, 32'h00000303);
    wb(1'b1, tog_pkg::REG_OUT_CTRL, 32'h00000024);
    wait_rises(3, 40000);
    `CHK("irig_period", 32'(tog_pkg::CLK_HZ / 10000), period)
    `CHK("out5_valid", 1'b0, out5_v)
    `CHK("out5", 1'b0, out5)
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    summarize();
  end
endmodule // tog_top_tb_top
`undef CHK
`default_nettype wire
